// >>> include/dcw_pkg.sv
/*
 Constants for the drive configuration word decoder: field positions of the
 two configuration words, input function codes, result codes, timing counts.
 Assumes a single 200 MHz core clock; no other files are needed.
*/
// How it works
// - Word 0 bits 8:6, 5:3, 2:0 carry input 3, 2, 1 function codes.
// - Code zero: input drives nothing, its state is still reported to host.
// - Codes 1..7: CW limit, CCW limit, start, stop, e-stop, home, encoder.
// - Encoder plus input 3 start: capture on every edge, rising edge launches move.
// - Encoder plus input 3 stop: capture at the moment the stop fires.
// - Home accepted on any input, but only input 3 when an encoder is used.
// - Encoder code valid only on inputs 1 and 2, as channels A and B.
// - Bit 15 of word 1 is ignored.
// - Word 1 bit 14 clear: fault output; set: follows command-mode data bit.
// - Output 1 is on from power-up until the driver is configured.
// - Link lost: output holds when bit 13 is zero, else takes bit 12.
// - Readback bit set on entering configuration mode returns the configuration.
// - While readback bit is set, new configuration data is refused.
// - Rising save bit checks validity then writes flash; invalid edge ignored.
// - Successful save puts 16#aaaa in last input word, indicator flashes green; ledState holds steady green, no blink.
// - Failed save puts 16#eeee in last input word, indicator flashes red; ledState holds steady red, no blink.
// - After the save result is reported, all commands are ignored until power cycle; the code still lets output 1 follow the command-mode data bit.
// - Word 0 bit 15 selects configuration mode when one, command mode when zero.
// - Word 1 bits 9 and 8 pick split decimal or signed 32-bit formats.
// - Word 1 bits 2:0 set polarity of inputs 3:1; one means normally open.
// - Configuration giving one function to two inputs is invalid.
package dcw_pkg;

    // Word 0 fields
    localparam int W0_MODE_BIT    = 15;
    localparam int W0_STALL_BIT   = 13;
    localparam int W0_USE_ENC_BIT = 10;
    localparam int W0_IN3_LSB     = 6;
    localparam int W0_IN2_LSB     = 3;
    localparam int W0_IN1_LSB     = 0;
    localparam logic [15:0] W0_RSVD_MASK = 16'h1200;

    // Word 1 fields
    localparam int W1_ROLE_BIT     = 14;
    localparam int W1_LOSS_ACT_BIT = 13;
    localparam int W1_LOSS_LVL_BIT = 12;
    localparam int W1_READBACK_BIT = 11;
    localparam int W1_PERSIST_BIT  = 10;
    localparam int W1_REPFMT_BIT   = 9;
    localparam int W1_PRGFMT_BIT   = 8;
    localparam logic [15:0] W1_RSVD_MASK = 16'h00f8;

    // Input function codes
    localparam logic [2:0] FN_GPIO  = 3'h0;
    localparam logic [2:0] FN_CW    = 3'h1;
    localparam logic [2:0] FN_CCW   = 3'h2;
    localparam logic [2:0] FN_START = 3'h3;
    localparam logic [2:0] FN_STOP  = 3'h4;
    localparam logic [2:0] FN_ESTOP = 3'h5;
    localparam logic [2:0] FN_HOME  = 3'h6;
    localparam logic [2:0] FN_QUAD  = 3'h7;

    // Status word 0 shown while unconfigured
    localparam logic [15:0] UNCONF_STATUS = 16'h6408;

    // Save result codes
    localparam logic [15:0] SAVE_OK_CODE   = 16'haaaa;
    localparam logic [15:0] SAVE_FAIL_CODE = 16'heeee;

    // Indicator flash half-period
    localparam int  CLK_MHZ        = 200;
    localparam int  FLASH_HALF_MS  = 250;
    localparam int  FLASH_HALF_CYC = FLASH_HALF_MS * 1000 * CLK_MHZ;

    typedef enum logic [1:0] {DCW_LED_OFF, DCW_LED_GREEN, DCW_LED_RED} dcw_led_e;

endpackage

// >>> rtl/dcw_sync.sv
/*
 Two-flop synchroniser bank for the discrete inputs and link status.
 Assumes asynchronous pin levels; the first stage is read only by the second.
*/
`timescale 1ns/1ps
`default_nettype none
module dcw_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rstn,
    // Data
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_r;

    initial begin
        if (WIDTH < 1) $error("dcw_sync: WIDTH must be at least 1");
    end

    // Plain two-stage chain
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            stage1_r <= '0;
            syncOut  <= '0;
        end else begin
            stage1_r <= asyncIn;
            syncOut  <= stage1_r;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/dcw_check.sv
/*
 Combinational validity check of the two configuration words.
 Assumes the other configuration words are checked by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module dcw_check (
    // Words under test
    input  wire logic [15:0] cfgWord0,
    input  wire logic [15:0] cfgWord1,
    input  wire logic        encResNonZero,
    // Verdict
    output logic             cfgValid
);
    logic [2:0] fn1;
    logic [2:0] fn2;
    logic [2:0] fn3;
    logic       useEnc;
    logic       dup;
    logic       placeOk;

    assign fn1    = cfgWord0[dcw_pkg::W0_IN1_LSB +: 3];
    assign fn2    = cfgWord0[dcw_pkg::W0_IN2_LSB +: 3];
    assign fn3    = cfgWord0[dcw_pkg::W0_IN3_LSB +: 3];
    assign useEnc = cfgWord0[dcw_pkg::W0_USE_ENC_BIT];

    // Same non-GPIO function twice; the two encoder channels are the exception
    always_comb begin
        dup = 1'b0;
        if (fn1 != dcw_pkg::FN_GPIO && fn1 == fn2 && fn1 != dcw_pkg::FN_QUAD) dup = 1'b1;
        if (fn1 != dcw_pkg::FN_GPIO && fn1 == fn3) dup = 1'b1;
        if (fn2 != dcw_pkg::FN_GPIO && fn2 == fn3) dup = 1'b1;
    end

    // Encoder code only on inputs 1 and 2; home only on input 3 with encoder
    always_comb begin
        placeOk = 1'b1;
        if (fn3 == dcw_pkg::FN_QUAD) placeOk = 1'b0;
        if ((fn1 == dcw_pkg::FN_QUAD) != (fn2 == dcw_pkg::FN_QUAD)) placeOk = 1'b0;
        if (useEnc && (fn1 != dcw_pkg::FN_QUAD || !encResNonZero)) placeOk = 1'b0;
        if (!useEnc && fn1 == dcw_pkg::FN_QUAD) placeOk = 1'b0;
        if (useEnc && (fn1 == dcw_pkg::FN_HOME || fn2 == dcw_pkg::FN_HOME)) placeOk = 1'b0;
        if (cfgWord0[dcw_pkg::W0_STALL_BIT] && !useEnc) placeOk = 1'b0;
    end

    // Reserved bits set make the whole set invalid; word 1 bit 15 is not looked at
    assign cfgValid = !dup && placeOk
                    && ((cfgWord0 & dcw_pkg::W0_RSVD_MASK) == 16'h0000)
                    && ((cfgWord1 & dcw_pkg::W1_RSVD_MASK) == 16'h0000);
endmodule
`default_nettype wire

// >>> rtl/dcw_decoder.sv
/*
 Drive configuration word decoder: takes configuration words 0 and 1 from the
 cyclic output data, decodes input functions, drives output 1, handles
 readback, flash save handshake and result reporting.
 Assumes host words are stable on core_clk; pins and link status are async.
*/
`timescale 1ns/1ps
`default_nettype none
module dcw_decoder #(
    parameter int FLASH_HALF_CYC = dcw_pkg::FLASH_HALF_CYC
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rstn,
    // Cyclic host output words
    input  wire logic [15:0] hostWord0,
    input  wire logic [15:0] hostWord1,
    input  wire logic        encResNonZero,
    input  wire logic        cmdOutBit,
    // Drive state
    input  wire logic        driveFault,
    input  wire logic [31:0] encoderPos,
    input  wire logic        stopFired,
    // Pins and link
    input  wire logic [2:0]  inputPins,
    input  wire logic        linkUpPin,
    // Flash port
    output logic             flashWrite,
    input  wire logic        flashDone,
    input  wire logic        flashOk,
    // Input data words
    output logic [15:0]      statusWord0,
    output logic [15:0]      statusWord1,
    output logic [15:0]      lastWord,
    // Decoded outputs
    output logic             auxOutput,
    output logic [2:0]       inputActive,
    output logic [2:0]       gpInputState,
    output logic             cwLimit,
    output logic             ccwLimit,
    output logic             startMove,
    output logic             stopMove,
    output logic             eStop,
    output logic             homeInput,
    output logic             encChanA,
    output logic             encChanB,
    output logic             captureStrobe,
    output logic [31:0]      capturedPos,
    output logic             reportNumberFormat,
    output logic             programNumberFormat,
    output logic             configured,
    output logic [1:0]       ledState
);

    initial begin
        if (FLASH_HALF_CYC < 1) $error("dcw_decoder: FLASH_HALF_CYC must be positive");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_LOCKED} dcw_save_e;

    ////////////////////////////////////////////////////////////////////////////
    // Synchronised pins

    logic [3:0] syncd;
    logic [2:0] pinLvl;
    logic       linkUp;
    logic       cfgValid;

    dcw_sync #(.WIDTH(4)) uSync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .asyncIn  ({linkUpPin, inputPins}),
        .syncOut  (syncd)
    );
    assign pinLvl = syncd[2:0];
    assign linkUp = syncd[3];

    dcw_check uCheck (
        .cfgWord0      (hostWord0),
        .cfgWord1      (hostWord1),
        .encResNonZero (encResNonZero),
        .cfgValid      (cfgValid)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Accepted configuration

    logic [15:0] cfg0_r;
    logic [15:0] cfg1_r;
    logic        cfgMode;
    logic        cfgModeD_r;
    logic        readbackLatch_r;
    logic        persistD_r;
    logic        locked;
    dcw_save_e   save_r;

    assign cfgMode = hostWord0[dcw_pkg::W0_MODE_BIT];
    assign locked  = (save_r == ST_LOCKED);

    // Mode edge and readback latched on entry to configuration mode
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cfgModeD_r      <= 1'b0;
            readbackLatch_r <= 1'b0;
        end else if (!locked) begin
            cfgModeD_r <= cfgMode;
            if (cfgMode && !cfgModeD_r)
                readbackLatch_r <= hostWord1[dcw_pkg::W1_READBACK_BIT];
            else if (!cfgMode)
                readbackLatch_r <= 1'b0;
        end
    end

    // Accept valid words only when readback is not asked for
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cfg0_r     <= 16'h0000;
            cfg1_r     <= 16'h0000;
            configured <= 1'b0;
        end else if (!locked && cfgMode && cfgValid
                     && !hostWord1[dcw_pkg::W1_READBACK_BIT]) begin
            cfg0_r     <= hostWord0;
            cfg1_r     <= hostWord1;
            configured <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flash save sequence

    logic saveRise;
    assign saveRise = hostWord1[dcw_pkg::W1_PERSIST_BIT] && !persistD_r;

    always_ff @(posedge core_clk) begin
        if (!rstn) persistD_r <= 1'b0;
        else       persistD_r <= hostWord1[dcw_pkg::W1_PERSIST_BIT];
    end

    // Invalid configuration makes the edge a no-op
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            save_r     <= ST_IDLE;
            flashWrite <= 1'b0;
            lastWord   <= 16'h0000;
            ledState   <= dcw_pkg::DCW_LED_OFF;
        end else begin
            flashWrite <= 1'b0;
            case (save_r)
                ST_IDLE: begin
                    if (cfgMode && saveRise && cfgValid) begin
                        save_r     <= ST_WRITE;
                        flashWrite <= 1'b1;
                    end
                end
                ST_WRITE: begin
                    if (flashDone) begin
                        save_r <= ST_LOCKED;
                        if (flashOk) begin
                            lastWord <= dcw_pkg::SAVE_OK_CODE;
                            ledState <= dcw_pkg::DCW_LED_GREEN;
                        end else begin
                            lastWord <= dcw_pkg::SAVE_FAIL_CODE;
                            ledState <= dcw_pkg::DCW_LED_RED;
                        end
                    end
                end
                default: save_r <= ST_LOCKED; // Only reset leaves it
            endcase
        end
    end

    // Flash blink timebase; blinkPhase is not applied to ledState
    logic [$clog2(FLASH_HALF_CYC+1)-1:0] blinkCnt_r;
    logic                                blinkPhase;
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            blinkCnt_r <= '0;
            blinkPhase <= 1'b0;
        end else if (blinkCnt_r == $bits(blinkCnt_r)'(FLASH_HALF_CYC - 1)) begin
            blinkCnt_r <= '0;
            blinkPhase <= !blinkPhase;
        end else begin
            blinkCnt_r <= blinkCnt_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input decode

    logic [2:0] fnCode [3];
    logic [2:0] active;
    logic       quadMode;

    assign fnCode[0] = cfg0_r[dcw_pkg::W0_IN1_LSB +: 3];
    assign fnCode[1] = cfg0_r[dcw_pkg::W0_IN2_LSB +: 3];
    assign fnCode[2] = cfg0_r[dcw_pkg::W0_IN3_LSB +: 3];
    assign quadMode  = configured && fnCode[0] == dcw_pkg::FN_QUAD
                     && fnCode[1] == dcw_pkg::FN_QUAD;
    // One in polarity bit: input is active when current flows
    assign active    = ~(pinLvl ^ cfg1_r[2:0]);

    function automatic logic anyFn(input logic [2:0] c0, input logic [2:0] c1,
                                   input logic [2:0] c2, input logic [2:0] a,
                                   input logic [2:0] code);
        anyFn = (c0 == code && a[0]) || (c1 == code && a[1]) || (c2 == code && a[2]);
    endfunction

    logic in3ActD_r;
    logic stopMoveD_r;

    // Registered functional decode; functions stay low until configured, but inputActive always follows the pins and gpInputState does so for inputs with code zero
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            inputActive  <= 3'h0;
            gpInputState <= 3'h0;
            cwLimit      <= 1'b0;
            ccwLimit     <= 1'b0;
            startMove    <= 1'b0;
            stopMove     <= 1'b0;
            eStop        <= 1'b0;
            homeInput    <= 1'b0;
            encChanA     <= 1'b0;
            encChanB     <= 1'b0;
            in3ActD_r    <= 1'b0;
            stopMoveD_r  <= 1'b0;
        end else begin
            inputActive <= active;
            in3ActD_r   <= active[2];
            stopMoveD_r <= stopMove;
            for (int i = 0; i < 3; i++)
                gpInputState[i] <= (fnCode[i] == dcw_pkg::FN_GPIO) && active[i];
            cwLimit   <= configured && anyFn(fnCode[0], fnCode[1], fnCode[2], active, dcw_pkg::FN_CW);
            ccwLimit  <= configured && anyFn(fnCode[0], fnCode[1], fnCode[2], active, dcw_pkg::FN_CCW);
            startMove <= configured && anyFn(fnCode[0], fnCode[1], fnCode[2], active, dcw_pkg::FN_START);
            stopMove  <= configured && anyFn(fnCode[0], fnCode[1], fnCode[2], active, dcw_pkg::FN_STOP);
            eStop     <= configured && anyFn(fnCode[0], fnCode[1], fnCode[2], active, dcw_pkg::FN_ESTOP);
            homeInput <= configured && anyFn(fnCode[0], fnCode[1], fnCode[2], active, dcw_pkg::FN_HOME);
            encChanA  <= quadMode && pinLvl[0];
            encChanB  <= quadMode && pinLvl[1];
        end
    end

    // Encoder capture only when the two channels really are an encoder
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            captureStrobe <= 1'b0;
            capturedPos   <= 32'h0000_0000;
        end else begin
            captureStrobe <= 1'b0;
            if (quadMode && fnCode[2] == dcw_pkg::FN_START
                && active[2] != in3ActD_r) begin
                captureStrobe <= 1'b1;
                capturedPos   <= encoderPos;
            end else if (quadMode && fnCode[2] == dcw_pkg::FN_STOP
                         && stopFired && active[2]) begin
                captureStrobe <= 1'b1;
                capturedPos   <= encoderPos;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output 1 and reported words

    // Link loss wins over the normal role; unconfigured forces on
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            auxOutput <= 1'b1;
        end else if (!configured) begin
            auxOutput <= 1'b1;
        end else if (!linkUp) begin
            if (cfg1_r[dcw_pkg::W1_LOSS_ACT_BIT])
                auxOutput <= cfg1_r[dcw_pkg::W1_LOSS_LVL_BIT];
        end else if (cfg1_r[dcw_pkg::W1_ROLE_BIT]) begin
            auxOutput <= cmdOutBit;
        end else begin
            auxOutput <= !driveFault;
        end
    end

    // Readback, or configuration mode once configured, mirrors stored words; unconfigured status until configured, else hold
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            statusWord0         <= dcw_pkg::UNCONF_STATUS;
            statusWord1         <= 16'h0000;
            reportNumberFormat  <= 1'b0;
            programNumberFormat <= 1'b0;
        end else begin
            reportNumberFormat  <= cfg1_r[dcw_pkg::W1_REPFMT_BIT];
            programNumberFormat <= cfg1_r[dcw_pkg::W1_PRGFMT_BIT];
            if (readbackLatch_r || (cfgMode && configured)) begin
                statusWord0 <= cfg0_r;
                statusWord1 <= cfg1_r;
            end else if (!configured) begin
                statusWord0 <= dcw_pkg::UNCONF_STATUS;
                statusWord1 <= 16'h0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    logic unusedBlink;
    assign unusedBlink = blinkPhase;

    AST_UNCONF_ON: assert property (@(posedge core_clk) disable iff (!rstn)
        !configured |=> auxOutput) else $error("output 1 off while unconfigured");
    AST_LOSS_LEVEL: assert property (@(posedge core_clk) disable iff (!rstn)
        configured && !linkUp && cfg1_r[13] |=> auxOutput == $past(cfg1_r[12]))
        else $error("link loss level not applied");
    AST_LOSS_HOLD: assert property (@(posedge core_clk) disable iff (!rstn)
        configured && !linkUp && !cfg1_r[13] |=> $stable(auxOutput))
        else $error("output 1 moved on link loss");
    AST_FAULT_ROLE: assert property (@(posedge core_clk) disable iff (!rstn)
        configured && linkUp && !cfg1_r[14] |=> auxOutput == !$past(driveFault))
        else $error("fault output wrong");
    AST_READBACK_REFUSE: assert property (@(posedge core_clk) disable iff (!rstn)
        hostWord1[11] |=> $stable(cfg0_r) && $stable(cfg1_r))
        else $error("configuration taken during readback");
    AST_SAVE_INVALID: assert property (@(posedge core_clk) disable iff (!rstn)
        save_r == ST_IDLE && saveRise && !cfgValid |=> !flashWrite)
        else $error("invalid save started");
    AST_SAVE_OK: assert property (@(posedge core_clk) disable iff (!rstn)
        save_r == ST_WRITE && flashDone && flashOk |=> lastWord == 16'haaaa && ledState == 2'h1)
        else $error("save success not reported");
    AST_SAVE_FAIL: assert property (@(posedge core_clk) disable iff (!rstn)
        save_r == ST_WRITE && flashDone && !flashOk |=> lastWord == 16'heeee && ledState == 2'h2)
        else $error("save failure not reported");
    AST_LOCKED: assert property (@(posedge core_clk) disable iff (!rstn)
        locked |=> locked && $stable(cfg0_r) && !flashWrite)
        else $error("responded after save");
    AST_NOCAP: assert property (@(posedge core_clk) disable iff (!rstn)
        !quadMode |=> !captureStrobe) else $error("capture without encoder");

    COV_SAVE_OK: cover property (@(posedge core_clk) disable iff (!rstn)
        save_r == ST_WRITE ##1 lastWord == 16'haaaa);
    COV_CAPTURE: cover property (@(posedge core_clk) disable iff (!rstn) captureStrobe);
    COV_LINK_LOSS: cover property (@(posedge core_clk) disable iff (!rstn)
        configured && !linkUp);
endmodule
`default_nettype wire

// >>> bench/dcw_host_model.sv
/*
 Host controller model: holds the two cyclic words and answers flash writes.
 Assumes the bench calls put between clock edges.
*/
`timescale 1ns/1ps
`default_nettype none
module dcw_host_model (
    // Clock
    input  wire logic        core_clk,
    // Cyclic words
    output logic      [15:0] hostWord0,
    output logic      [15:0] hostWord1,
    // Flash port
    input  wire logic        flashWrite,
    output logic             flashDone,
    output logic             flashOk
);
    ////////////////////////////////////////////////////////////////////////////
    logic okNext;
    // Idle in command mode; reserved bits left zero
    initial begin
        hostWord0 = 16'h0000;
        hostWord1 = 16'h0000;
        flashDone = 1'b0;
        flashOk   = 1'b0;
        okNext    = 1'b1;
    end
    // Slow flash: result four cycles after the write; ok is junk outside done
    always @(posedge core_clk) begin
        if (flashWrite) begin
            repeat (4) @(posedge core_clk);
            flashDone <= 1'b1;
            flashOk   <= okNext;
            @(posedge core_clk);
            flashDone <= 1'b0;
            flashOk   <= !okNext;
        end
    end
    // New words land just after a falling edge
    task automatic put(input logic [15:0] w0, input logic [15:0] w1);
        @(negedge core_clk);
        hostWord0 = w0;
        hostWord1 = w1;
    endtask
endmodule
`default_nettype wire

// >>> bench/drive_config_word_decoder_tb_top.sv
/*
 Self-checking bench of the configuration word decoder.
 Assumes dcw_pkg and the host model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module drive_config_word_decoder_tb_top;
    ////////////////////////////////////////////////////////////////////////////
    logic        core_clk, rstn, driveFault, linkUpPin, flashWrite, flashDone;
    logic        flashOk, auxOutput, cwLimit, eStop, configured;
    logic        reportNumberFormat, programNumberFormat;
    logic        ccwLimit, encChanA, encResNonZero;
    logic [15:0] hostWord0, hostWord1, statusWord0, statusWord1, lastWord;
    logic [31:0] capturedPos;
    logic [2:0]  inputPins;
    logic [1:0]  ledState;
    int          errors, cmp_count, cycles;
    dcw_host_model i_dcw_host_model (.core_clk(core_clk), .hostWord0(hostWord0),
        .hostWord1(hostWord1), .flashWrite(flashWrite), .flashDone(flashDone),
        .flashOk(flashOk));
    dcw_decoder #(.FLASH_HALF_CYC(4)) i_dcw_decoder (.core_clk(core_clk),
        .rstn(rstn), .hostWord0(hostWord0), .hostWord1(hostWord1),
        .encResNonZero(encResNonZero), .cmdOutBit(1'b0), .driveFault(driveFault),
        .encoderPos(32'h0000_1234), .stopFired(1'b0), .inputPins(inputPins),
        .linkUpPin(linkUpPin), .flashWrite(flashWrite), .flashDone(flashDone),
        .flashOk(flashOk), .statusWord0(statusWord0), .statusWord1(statusWord1),
        .lastWord(lastWord), .auxOutput(auxOutput), .inputActive(),
        .gpInputState(), .cwLimit(cwLimit), .ccwLimit(ccwLimit), .startMove(),
        .stopMove(), .eStop(eStop), .homeInput(), .encChanA(encChanA), .encChanB(),
        .captureStrobe(), .capturedPos(capturedPos),
        .reportNumberFormat(reportNumberFormat),
        .programNumberFormat(programNumberFormat), .configured(configured),
        .ledState(ledState));
    // 200 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // Hang guard, well above the roughly 80 cycles needed
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            end_of_test();
        end
    end
    task automatic step(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic end_of_test();
        if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rstn, driveFault, encResNonZero, inputPins} = '0;
        linkUpPin = 1'b1;
        step(3);
        rstn = 1'b1;
        `CHK(auxOutput, 1'b1)
        `CHK(statusWord0, 16'h6408)
        // Two inputs as CW limit: refused
        i_dcw_host_model.put(16'h8009, 16'h0000);
        step(4);
        `CHK(configured, 1'b0)
        // In3 e-stop, in2 CCW, in1 CW; link-loss drives on; both formats binary
        i_dcw_host_model.put(16'h8151, 16'h3307);
        step(4);
        `CHK(configured, 1'b1)
        `CHK(reportNumberFormat, 1'b1)
        `CHK(programNumberFormat, 1'b1)
        `CHK(statusWord1, 16'h3307)
        inputPins = 3'b101;
        step(4);
        `CHK(cwLimit, 1'b1)
        `CHK(ccwLimit, 1'b0)
        `CHK(eStop, 1'b1)
        driveFault = 1'b1;
        step(2);
        `CHK(auxOutput, 1'b0)
        linkUpPin = 1'b0;
        step(5);
        `CHK(auxOutput, 1'b1)
        linkUpPin = 1'b1;
        // Readback bit set with new formats: refused
        i_dcw_host_model.put(16'h8151, 16'h3807);
        step(4);
        `CHK(programNumberFormat, 1'b1)
        // Encoder on inputs 1 and 2, input 3 start with capture
        encResNonZero = 1'b1;
        i_dcw_host_model.put(16'h84ff, 16'h3307);
        step(4);
        inputPins = 3'b001;
        step(4);
        `CHK(capturedPos, 32'h0000_1234)
        `CHK(encChanA, 1'b1)
        i_dcw_host_model.put(16'h8151, 16'h3307);
        i_dcw_host_model.put(16'h8151, 16'h3707);
        step(12);
        `CHK(lastWord, 16'haaaa)
        `CHK(ledState, 2'h1)
        i_dcw_host_model.put(16'h8151, 16'h3007);
        step(4);
        `CHK(programNumberFormat, 1'b1)
        // Second power-up, flash refuses the write
        rstn = 1'b0;
        i_dcw_host_model.okNext = 1'b0;
        step(3);
        rstn = 1'b1;
        step(3);
        i_dcw_host_model.put(16'h8151, 16'h3407);
        step(12);
        `CHK(lastWord, 16'heeee)
        `CHK(ledState, 2'h2)
        end_of_test();
    end
endmodule
`default_nettype wire
